// file: verilog/gsrs_pkg.sv
// Shared constants and types for the gas sensor ready sequencer
package gsrs_pkg;
    // ==========================================================
    // Clock and timing figures
    localparam int CLK_HZ = 20_000_000;
    localparam int PERIOD_MS = 500;        // Ready pulse period
    localparam int PULSE_US = 16_500;      // Ready high width
    localparam int FIRST_MIN_MS = 800;     // Earliest first valid pulse
    localparam int SETUP_MS = 14;          // Host setup after falling edge
    localparam int LOW_MAX_MS = 100;       // Ready low from power-on, latest
    localparam int BAUD_RATE = 9600;
    localparam int PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
    localparam int PULSE_CYC = CLK_HZ / 1_000_000 * PULSE_US;
    localparam int FIRST_CYC = CLK_HZ / 1000 * FIRST_MIN_MS;
    localparam int SETUP_CYC = (CLK_HZ / 1000 * SETUP_MS + 0);
    localparam int LOW_MAX_CYC = CLK_HZ / 1000 * LOW_MAX_MS;
    localparam int BAUD_CYC = CLK_HZ / BAUD_RATE;   // Rounds down
    localparam int CNT_W = 24;
    localparam int STRAP_WAIT = 3;         // Cycles for pin synchroniser to fill
    // ==========================================================
    // Reset values and field widths
    localparam logic [7:0] FILT_MIN = 8'h01;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [16:0] ZERO_RST = 17'h00000;
    localparam int WARM_SHIFT = 4;         // Filter setting to warm-up samples
    // ==========================================================
    // Host commands
    typedef enum logic [1:0] {
        GSRS_CMD_READ = 2'h0,
        GSRS_CMD_SET_REF = 2'h1,
        GSRS_CMD_ZERO_KNOWN = 2'h2,
        GSRS_CMD_ZERO_N2 = 2'h3
    } gsrs_cmd_t;
    typedef struct packed {
        gsrs_cmd_t cmd;
        logic [15:0] data;
    } gsrs_req_t;
    typedef struct packed {
        logic [15:0] filtered;
        logic [15:0] raw;
    } gsrs_rsp_t;
    // Sequencer states
    typedef enum logic [2:0] {
        GSRS_ST_STRAP = 3'h1,
        GSRS_ST_WARM = 3'h2,
        GSRS_ST_RUN = 3'h4
    } gsrs_state_t;
endpackage : gsrs_pkg

// file: verilog/gsrs_filter.sv
// First-order low-pass smoothing of the corrected measurement
`timescale 1ns/10ps
module gsrs_filter (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [15:0] in_data,
    input wire logic [7:0] setting,
    output logic [15:0] out_data
);
    // ==========================================================
    // Step toward the new sample by diff / setting
    logic [15:0] y_r;
    logic [15:0] y_nxt;
    logic [7:0] div;
    logic signed [17:0] diff;
    logic signed [17:0] step;
    // Setting 0 is treated as 1 so the divider never sees zero
    assign div = (setting < gsrs_pkg::FILT_MIN) ? gsrs_pkg::FILT_MIN : setting;
    assign diff = $signed({2'b00, in_data}) - $signed({2'b00, y_r});
    assign step = diff / $signed({10'h000, div});
    assign y_nxt = 16'($signed({2'b00, y_r}) + step);
    assign out_data = y_r;

    // Output register
    always_ff @(posedge clock) begin
        if (srst) begin
            y_r <= gsrs_pkg::DATA_RST;
        end else if (in_valid) begin
            y_r <= y_nxt;
        end
    end

    // ==========================================================
    // Checks
    unfilt_pass_a: assert property (@(posedge clock) disable iff (srst)
        (in_valid && setting == 8'h01) |=> (out_data == $past(in_data)))
        else $error("setting one does not pass samples through");
    hold_idle_a: assert property (@(posedge clock) disable iff (srst)
        !in_valid |=> $stable(out_data))
        else $error("filter output moved without a sample");
endmodule : gsrs_filter

// file: verilog/gsrs_seq.sv
// Power-on mode strap, measurement schedule, ready pulse and host access gate
`timescale 1ns/10ps
module gsrs_seq #(
    parameter int PER_CYC = gsrs_pkg::PERIOD_CYC,
    parameter int PUL_CYC = gsrs_pkg::PULSE_CYC,
    parameter int FST_CYC = gsrs_pkg::FIRST_CYC,
    parameter int SET_CYC = gsrs_pkg::SETUP_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic bus_sel_n,
    input wire logic [15:0] sample_in,
    input wire logic [7:0] filt_setting,
    input wire logic req_valid,
    input wire gsrs_pkg::gsrs_req_t req,
    output logic req_ack,
    output gsrs_pkg::gsrs_rsp_t rsp,
    output logic mode_i2c,
    output logic ready,
    output logic host_open,
    output logic meas_strobe,
    output logic baud_tick
);
    // ==========================================================
    // Declarations
    localparam logic [gsrs_pkg::CNT_W-1:0] PER_LAST = gsrs_pkg::CNT_W'(PER_CYC - 1);
    localparam logic [gsrs_pkg::CNT_W-1:0] PUL_LAST = gsrs_pkg::CNT_W'(PUL_CYC - 1);
    localparam logic [gsrs_pkg::CNT_W-1:0] FST_LIM = gsrs_pkg::CNT_W'(FST_CYC);
    localparam logic [gsrs_pkg::CNT_W-1:0] SET_LIM = gsrs_pkg::CNT_W'(SET_CYC);
    localparam logic [11:0] BAUD_LAST = 12'(gsrs_pkg::BAUD_CYC - 1);
    localparam logic [1:0] STRAP_LAST = 2'(gsrs_pkg::STRAP_WAIT - 1);

    gsrs_pkg::gsrs_state_t st_r;
    gsrs_pkg::gsrs_state_t st_nxt;
    logic sel_s1_r;
    logic sel_s2_r;
    logic [1:0] strap_cnt_r;
    logic mode_i2c_r;
    logic [gsrs_pkg::CNT_W-1:0] per_cnt_r;
    logic [gsrs_pkg::CNT_W-1:0] elap_r;
    logic [gsrs_pkg::CNT_W-1:0] pul_cnt_r;
    logic [gsrs_pkg::CNT_W-1:0] set_cnt_r;
    logic [7:0] samp_cnt_r;
    logic ready_r;
    logic meas_strobe_r;
    logic first_done_r;
    logic [11:0] baud_cnt_r;
    logic baud_tick_r;
    logic [15:0] raw_r;
    logic [15:0] ref_ppm_r;
    logic signed [16:0] zero_r;
    gsrs_pkg::gsrs_rsp_t rsp_r;
    logic meas_tick;
    logic warm_met;
    logic pulse_start;
    logic pulse_end;
    logic accept;
    logic [7:0] warm_need;
    logic signed [17:0] corr_full;
    logic [15:0] corr;
    logic [15:0] filt_out;
    logic signed [16:0] known_off;

    // ==========================================================
    // Bus-select pin synchroniser and one-time strap
    always_ff @(posedge clock) begin
        if (srst) begin
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
        end else begin
            sel_s1_r <= bus_sel_n;
            sel_s2_r <= sel_s1_r;
        end
    end

    // Strap waits for the synchroniser to fill, then never looks again
    always_ff @(posedge clock) begin
        if (srst) begin
            strap_cnt_r <= 2'h0;
            mode_i2c_r <= 1'b0;
        end else if (st_r == gsrs_pkg::GSRS_ST_STRAP) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_LAST) begin
                mode_i2c_r <= ~sel_s2_r;
            end
        end
    end

    // ==========================================================
    // Sequencer state
    assign meas_tick = (st_r != gsrs_pkg::GSRS_ST_STRAP) && (per_cnt_r == PER_LAST);
    assign warm_need = filt_setting >> gsrs_pkg::WARM_SHIFT;
    // Stronger filtering needs more settled samples before the first valid pulse
    assign warm_met = (elap_r >= FST_LIM) && (samp_cnt_r >= warm_need);
    assign pulse_start = meas_tick && (st_r == gsrs_pkg::GSRS_ST_RUN
        || (st_r == gsrs_pkg::GSRS_ST_WARM && warm_met));
    assign pulse_end = ready_r && (pul_cnt_r == PUL_LAST);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            gsrs_pkg::GSRS_ST_STRAP: begin
                if (strap_cnt_r == STRAP_LAST) begin
                    st_nxt = gsrs_pkg::GSRS_ST_WARM;
                end
            end
            gsrs_pkg::GSRS_ST_WARM: begin
                if (pulse_start) begin
                    st_nxt = gsrs_pkg::GSRS_ST_RUN;
                end
            end
            gsrs_pkg::GSRS_ST_RUN: begin
                st_nxt = gsrs_pkg::GSRS_ST_RUN;
            end
            default: begin
                st_nxt = gsrs_pkg::GSRS_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= gsrs_pkg::GSRS_ST_STRAP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Measurement period counter free running in both modes; warm-up counters stop at their limits
    always_ff @(posedge clock) begin
        if (srst || st_r == gsrs_pkg::GSRS_ST_STRAP) begin
            per_cnt_r <= '0;
            elap_r <= '0;
            samp_cnt_r <= 8'h00;
        end else begin
            per_cnt_r <= meas_tick ? '0 : per_cnt_r + 1'b1;
            if (elap_r < FST_LIM) begin
                elap_r <= elap_r + 1'b1;
            end
            if (meas_tick && samp_cnt_r != 8'hFF) begin
                samp_cnt_r <= samp_cnt_r + 8'h01;
            end
        end
    end

    // Ready pulse; low from reset so it is low far inside the power-on limit
    always_ff @(posedge clock) begin
        if (srst) begin
            ready_r <= 1'b0;
            pul_cnt_r <= '0;
            first_done_r <= 1'b0;
            meas_strobe_r <= 1'b0;
        end else begin
            meas_strobe_r <= meas_tick;
            if (pulse_start) begin
                ready_r <= 1'b1;
                pul_cnt_r <= '0;
                first_done_r <= 1'b1;
            end else if (pulse_end) begin
                ready_r <= 1'b0;
            end else if (ready_r) begin
                pul_cnt_r <= pul_cnt_r + 1'b1;
            end
        end
    end

    // Setup window after the falling edge, shown to the host as host_open
    always_ff @(posedge clock) begin
        if (srst || ready_r) begin
            set_cnt_r <= '0;
        end else if (first_done_r && set_cnt_r < SET_LIM) begin
            set_cnt_r <= set_cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // UART bit-rate enable, fixed, only in UART mode
    always_ff @(posedge clock) begin
        if (srst || mode_i2c_r || st_r == gsrs_pkg::GSRS_ST_STRAP) begin
            baud_cnt_r <= 12'h000;
            baud_tick_r <= 1'b0;
        end else begin
            baud_tick_r <= (baud_cnt_r == BAUD_LAST);
            baud_cnt_r <= (baud_cnt_r == BAUD_LAST) ? 12'h000 : baud_cnt_r + 12'h001;
        end
    end

    // ==========================================================
    // Zero correction, filtering and sample capture
    assign corr_full = $signed({2'b00, sample_in}) - 18'(zero_r);
    assign corr = corr_full[17] ? 16'h0000 : (corr_full[16] ? 16'hFFFF : corr_full[15:0]);
    assign known_off = $signed({1'b0, raw_r}) - $signed({1'b0, ref_ppm_r});

    gsrs_filter u_filter (
        .clock(clock),
        .srst(srst),
        .in_valid(meas_tick),
        .in_data(corr),
        .setting(filt_setting),
        .out_data(filt_out)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            raw_r <= gsrs_pkg::DATA_RST;
        end else if (meas_tick) begin
            raw_r <= corr;
        end
    end

    // ==========================================================
    // Host access gate; the host is trusted to honour the setup delay
    assign accept = req_valid && first_done_r && !ready_r;
    assign req_ack = accept;
    assign host_open = first_done_r && !ready_r && (set_cnt_r >= SET_LIM);

    // Commands; each zero adds its offset to the previous one, never overwrites it
    always_ff @(posedge clock) begin
        if (srst) begin
            ref_ppm_r <= gsrs_pkg::DATA_RST;
            zero_r <= gsrs_pkg::ZERO_RST;
            rsp_r <= '0;
        end else if (accept) begin
            rsp_r.filtered <= filt_out;
            rsp_r.raw <= raw_r;
            unique case (req.cmd)
                gsrs_pkg::GSRS_CMD_SET_REF: ref_ppm_r <= req.data;
                gsrs_pkg::GSRS_CMD_ZERO_KNOWN: zero_r <= zero_r + known_off;
                gsrs_pkg::GSRS_CMD_ZERO_N2: zero_r <= zero_r + $signed({1'b0, raw_r});
                gsrs_pkg::GSRS_CMD_READ: ref_ppm_r <= ref_ppm_r;
            endcase
        end
    end

    assign rsp = rsp_r;
    assign mode_i2c = mode_i2c_r;
    assign ready = ready_r;
    assign meas_strobe = meas_strobe_r;
    assign baud_tick = baud_tick_r;

    // ==========================================================
    // Check helper: cycles since the last pulse start, so the period
    // can be checked without a long repetition in a property
    logic [gsrs_pkg::CNT_W-1:0] chk_gap_r;
    logic chk_seen_r;

    // Saturates rather than wraps, so a stalled schedule cannot look right
    always_ff @(posedge clock) begin
        if (srst) begin
            chk_gap_r <= '0;
            chk_seen_r <= 1'b0;
        end else if (pulse_start) begin
            chk_gap_r <= '0;
            chk_seen_r <= 1'b1;
        end else if (chk_gap_r != '1) begin
            chk_gap_r <= chk_gap_r + 1'b1;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    strap_stable_a: assert property (
        (st_r != gsrs_pkg::GSRS_ST_STRAP && $past(st_r) != gsrs_pkg::GSRS_ST_STRAP)
        |-> $stable(mode_i2c))
        else $error("interface mode changed after strap");
    auto_meas_a: assert property (
        (st_r != gsrs_pkg::GSRS_ST_STRAP && per_cnt_r == PER_LAST) |=> meas_strobe)
        else $error("measurement not started at period end");
    pulse_data_a: assert property (
        $rose(ready) |-> $past(meas_tick))
        else $error("ready rose without a new measurement");
    no_early_ack_a: assert property (
        !first_done_r |-> !req_ack)
        else $error("request answered before first ready pulse");
    first_delay_a: assert property (
        ($rose(ready) && !$past(first_done_r)) |-> $past(elap_r) >= FST_LIM)
        else $error("first ready pulse too early");
    low_at_start_a: assert property (
        !first_done_r |-> !ready)
        else $error("ready high before first valid pulse");
    pulse_width_a: assert property (
        $fell(ready) |-> $past(pul_cnt_r) == PUL_LAST)
        else $error("ready pulse width wrong");
    busy_ignore_a: assert property (
        ready |-> !req_ack)
        else $error("access accepted while ready high");
    period_repeat_a: assert property (
        (first_done_r && meas_tick) |=> ready)
        else $error("ready did not repeat at period end");
    n2_zero_a: assert property (
        (accept && req.cmd == gsrs_pkg::GSRS_CMD_ZERO_N2)
        |=> zero_r == $past(zero_r) + $signed({1'b0, $past(raw_r)}))
        else $error("nitrogen zero not applied");

    // Refusals leave calibration state alone; window shut at each fall
    refused_hold_a: assert property (
        (ready || !first_done_r) |=> ($stable(zero_r) && $stable(ref_ppm_r)))
        else $error("refused request changed calibration state");
    fall_closed_a: assert property (
        $fell(ready) |-> !host_open)
        else $error("host window open at ready fall");

    // Bit-rate enable, capture and calibration writes
    uart_baud_a: assert property (
        baud_tick |-> !mode_i2c)
        else $error("bit-rate enable running in two-wire mode");
    raw_capture_a: assert property (
        meas_tick |=> raw_r == $past(corr))
        else $error("raw value not captured at period end");
    ref_write_a: assert property (
        (accept && req.cmd == gsrs_pkg::GSRS_CMD_SET_REF) |=> ref_ppm_r == $past(req.data))
        else $error("reference concentration not stored");
    known_zero_a: assert property (
        (accept && req.cmd == gsrs_pkg::GSRS_CMD_ZERO_KNOWN)
        |=> zero_r == $past(zero_r) + $past(known_off))
        else $error("known gas zero not applied");

    // Period, counted by the helper above
    period_gap_a: assert property (
        (pulse_start && chk_seen_r) |-> chk_gap_r == PER_LAST)
        else $error("ready period wrong");
endmodule : gsrs_seq

// file: verification/gsrs_host_model.sv
// Host controller model for the request port of the ready sequencer
`timescale 1ns/10ps
module gsrs_host_model (
    input wire logic clock,
    input wire logic ready,
    input wire logic host_open,
    input wire logic req_ack,
    output logic req_valid,
    output gsrs_pkg::gsrs_req_t req
);
    // ==========================================================
    // Idle request port
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // Polite access: wait out the setup window, offer for one cycle and retry until taken
    // Reads may follow each other at any rate; no baud setting exists here
    // A pulse that starts under a pending request gets it dropped and retried
    task automatic send(input gsrs_pkg::gsrs_cmd_t cmd, input logic [15:0] data);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        while (!done && n < 3000) begin
            @(negedge clock);
            n++;
            if (host_open === 1'b1 && ready === 1'b0) begin
                @(posedge clock);
                req_valid <= 1'b1;
                req <= {cmd, data};
                @(posedge clock);
                done = (req_ack === 1'b1);
                req_valid <= 1'b0;
                req.data <= ~data; // Stale data inverted, never left looking valid
            end
        end
    endtask : send
    // Deliberately rude access, used only to provoke a refusal
    task automatic poke(input gsrs_pkg::gsrs_cmd_t cmd, input int cycles);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= {cmd, 16'h5A5A};
        repeat (cycles) @(posedge clock);
        req_valid <= 1'b0;
    endtask : poke
endmodule : gsrs_host_model

// file: verification/gsrs_seq_tb_top.sv
// Self-checking bench for the ready sequencer
`timescale 1ns/10ps
module gsrs_seq_tb_top;
    // ==========================================================
    // Shrunk timing so the run stays short
    localparam int PER = 64;
    localparam int PUL = 8;
    localparam int FST = 100;
    localparam int SET = 6;
    localparam gsrs_pkg::gsrs_cmd_t RD = gsrs_pkg::GSRS_CMD_READ;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic bus_sel_n = 1'b1;
    logic [15:0] sample_in = 16'h0000;
    logic [7:0] filt_setting = 8'h01;
    logic req_valid, req_ack, mode_i2c, ready, host_open, meas_strobe, baud_tick;
    gsrs_pkg::gsrs_req_t req;
    gsrs_pkg::gsrs_rsp_t rsp;
    int n_mismatch = 0;
    int comparisons = 0;
    int first_min = FST;
    int since, hi_len, gap, sgap, bgap, n_rise, n_strb, n_baud, lowc;
    logic rd_pend = 1'b0;
    logic ready_d = 1'b0;
    logic open_d = 1'b0;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [15:0] s, r;
    always #25 clock = ~clock;
    gsrs_seq #(.PER_CYC(PER), .PUL_CYC(PUL), .FST_CYC(FST), .SET_CYC(SET)) uut (
        .clock(clock), .srst(srst), .bus_sel_n(bus_sel_n), .sample_in(sample_in),
        .filt_setting(filt_setting), .req_valid(req_valid), .req(req),
        .req_ack(req_ack), .rsp(rsp), .mode_i2c(mode_i2c), .ready(ready),
        .host_open(host_open), .meas_strobe(meas_strobe), .baud_tick(baud_tick));
    gsrs_host_model host (.clock(clock), .ready(ready), .host_open(host_open),
        .req_ack(req_ack), .req_valid(req_valid), .req(req));
    // ==========================================================
    // Comparison, closing and timeout
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #(30000 * 50);
        n_mismatch++;
        $display("Watchdog expired");
        end_of_test();
    end
    // ==========================================================
    // Output watcher: pulse shape, period, strobes, gate and read results
    always @(posedge clock) begin
        if (rd_pend && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk("rsp", note[31:0], rsp & note[63:32]);
        end
        rd_pend <= req_ack === 1'b1 && req.cmd == RD;
        if (srst === 1'b1) begin
            {since, hi_len, gap, sgap, bgap, n_rise, n_strb, n_baud, lowc} = '0;
            ready_d = 1'b0;
            open_d = 1'b0;
        end else begin
            since++;
            lowc++;
            gap++;
            sgap++;
            bgap++;
            if (req_ack === 1'b1) chk("ack gate", 1, ready === 1'b0 && n_rise > 0);
            if (ready === 1'b1 && ready_d !== 1'b1) begin
                if (n_rise == 0) chk("first delay", 1, since >= first_min);
                else chk("ready period", PER, gap);
                chk("strobe at ready", 1, meas_strobe);
                n_rise++;
                gap = 0;
            end
            if (ready === 1'b1) hi_len++;
            if (ready !== 1'b1 && ready_d === 1'b1) begin
                chk("ready width", PUL, hi_len);
                lowc = 0;
            end
            if (host_open === 1'b1 && open_d !== 1'b1) chk("setup wait", SET, lowc);
            if (ready !== 1'b1) hi_len = 0;
            if (meas_strobe === 1'b1) begin
                if (n_strb > 0) chk("strobe period", PER, sgap);
                n_strb++;
                sgap = 0;
            end
            if (baud_tick === 1'b1) begin
                if (n_baud > 0) chk("baud gap", gsrs_pkg::BAUD_CYC, bgap);
                n_baud++;
                bgap = 0;
            end
            ready_d = ready;
            open_d = host_open;
        end
    end
    // ==========================================================
    // Helpers for the scenarios
    task automatic rd(input logic [63:0] n);
        exp_q.push_back(n);
        host.send(RD, 16'h0000);
    endtask : rd
    task automatic wait_rises(input int cnt);
        int k, g;
        k = n_rise + cnt;
        g = 0;
        while (n_rise < k && g < 3000) begin
            @(negedge clock);
            g++;
        end
        chk("ready seen", 1, n_rise >= k);
    endtask : wait_rises
    task automatic start(input logic sel, input logic [7:0] filt);
        @(posedge clock);
        srst <= 1'b1;
        bus_sel_n <= sel;
        filt_setting <= filt;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (6) @(posedge clock);
        bus_sel_n <= ~sel; // Late change must not move the mode
    endtask : start
    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(67557));
        s = 16'h2000 + 16'($urandom_range(16'hDFFF));
        r = 16'($urandom_range(32'(s) - 1));
        sample_in <= s;
        start(1'b1, 8'h01);
        host.poke(RD, 10);
        wait_rises(1);
        rd({32'hFFFFFFFF, s, s});
        rd({32'hFFFFFFFF, s, s});
        wait_rises(1);
        host.poke(gsrs_pkg::GSRS_CMD_ZERO_N2, 4);
        rd({32'hFFFFFFFF, s, s});
        host.send(gsrs_pkg::GSRS_CMD_ZERO_N2, 16'h0000);
        wait_rises(1);
        rd({32'hFFFFFFFF, 32'h00000000});
        host.send(gsrs_pkg::GSRS_CMD_SET_REF, r);
        host.send(gsrs_pkg::GSRS_CMD_ZERO_KNOWN, 16'h0000);
        wait_rises(1);
        rd({32'hFFFFFFFF, r, r});
        repeat (4300) @(posedge clock);
        chk("uart mode", 0, mode_i2c);
        $display("Test uart mode done");
        first_min = (255 >> 4) * PER;
        start(1'b0, 8'hFF);
        wait_rises(2);
        rd({32'h0000FFFF, 16'h0000, s});
        @(negedge clock);
        chk("slow filter", 1, rsp.filtered < rsp.raw);
        chk("i2c mode", 1, mode_i2c);
        chk("no baud in i2c", 0, n_baud);
        repeat (2) @(posedge clock);
        chk("reads drained", 0, exp_q.size());
        $display("Test i2c mode done");
        end_of_test();
    end
endmodule : gsrs_seq_tb_top
